// *** core/sadc_top.sv ***
/*
 Digital audio input path of a mono amplifier: three control registers,
 serial audio receiver on the bit clock, word crossing, sample FIFO and
 output processing (highpass, volume, mute, invert).
 Assumes the bit clock and frame sync come from the audio source and that
 the register port and sample consumer run on i_clk_sys.
*/
`default_nettype none

module sadc_fifo
   import sadc_pkg::*;
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
)
(
   input  wire  logic             i_clk_sys,
   input  wire  logic             i_reset,
   input  wire  logic             i_clk_en,
   // Fill side
   input  wire  logic             i_in_valid,
   output logic                   o_in_ready,
   input  wire  logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic                   o_out_valid,
   input  wire  logic             i_out_ready,
   output logic [WIDTH-1:0]       o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];

   always_ff @(posedge i_clk_sys)
   begin
      if (i_clk_en && push)
      begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else if (i_clk_en)
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module sadc_top
   import sadc_pkg::*;
#(
   parameter int FIFO_DEPTH = SADC_FIFO_DEPTH
)
(
   // System clock domain
   input  wire  logic                   i_clk_sys,
   input  wire  logic                   i_reset,
   input  wire  logic                   i_clk_en,
   // Register port
   input  wire  logic [7:0]             i_reg_addr,
   input  wire  logic [7:0]             i_reg_wdata,
   input  wire  logic                   i_reg_wr,
   input  wire  logic                   i_reg_rd,
   output logic [7:0]                   o_reg_rdata,
   // Settings held outside these registers
   input  wire  logic                   i_data_width_16,
   input  wire  logic                   i_auto_slot,
   input  wire  logic [3:0]             i_slot_number,
   input  wire  logic [1:0]             i_addr_slot,
   // Serial audio link
   input  wire  logic                   i_bit_clock,
   input  wire  logic                   i_frame_sync,
   input  wire  logic                   i_serial_audio_in,
   // Processed samples
   output logic [SADC_WORD_W-1:0]       o_audio,
   output logic                         o_audio_valid,
   input  wire  logic                   i_audio_ready,
   // Status
   output logic                         o_in_ready,
   output logic                         o_overrun,
   output logic                         o_converter_low_power,
   output logic [SADC_RATE_BANDS-1:0]   o_sample_rate_range,
   output logic                         o_rate_reserved
);
   localparam int CFG_W = 12;

   logic [7:0] conv_r;
   logic [7:0] vol_r;
   logic [7:0] spc1_r;

   // Register port
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         conv_r      <= SADC_RST_CONV;
         vol_r       <= SADC_RST_VOL;
         spc1_r      <= SADC_RST_SPC1;
         o_reg_rdata <= 8'h00;
      end
      else if (i_clk_en)
      begin
         if (i_reg_wr)
         begin
            unique case (i_reg_addr)
               SADC_OFS_CONV: conv_r <= i_reg_wdata;
               SADC_OFS_VOL:  vol_r  <= i_reg_wdata;
               SADC_OFS_SPC1: spc1_r <= i_reg_wdata;
               default:       ;
            endcase
         end
         if (i_reg_rd)
         begin
            unique case (i_reg_addr)
               SADC_OFS_CONV: o_reg_rdata <= conv_r;
               SADC_OFS_VOL:  o_reg_rdata <= vol_r;
               SADC_OFS_SPC1: o_reg_rdata <= spc1_r;
               default:       o_reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Rate band decode and low-power flag
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         o_sample_rate_range   <= '0;
         o_rate_reserved       <= 1'b0;
         o_converter_low_power <= 1'b1;
      end
      else if (i_clk_en)
      begin
         o_converter_low_power <= conv_r[SADC_BIT_LOWPOWER];                   // [R3]
         o_sample_rate_range   <= '0;
         o_rate_reserved       <= (conv_r[SADC_RATE_LSB +: 3] > 3'd5);         // [R1]
         if (conv_r[SADC_RATE_LSB +: 3] <= 3'd5)
         begin
            o_sample_rate_range[conv_r[SADC_RATE_LSB +: 3]] <= 1'b1;          // [R1]
         end
      end
   end

   // Link configuration, quasi-static, crossed as levels
   logic [CFG_W-1:0] cfg_sys;
   logic [CFG_W-1:0] cfg_meta_r;
   logic [CFG_W-1:0] cfg_r;
   logic [1:0]       lrst_r;
   logic [3:0]       slot_sel;

   assign slot_sel = i_auto_slot ? {2'b00, i_addr_slot} : i_slot_number;     // [R15]
   assign cfg_sys  = {i_data_width_16, slot_sel, spc1_r[SADC_SLOTLEN_LSB +: 3],
                      spc1_r[SADC_BIT_EDGE], spc1_r[SADC_BIT_STYLE],
                      spc1_r[SADC_BIT_ALIGN], spc1_r[SADC_BIT_MODE]};

   always_ff @(posedge i_bit_clock)
   begin
      cfg_meta_r <= cfg_sys;
      cfg_r      <= cfg_meta_r;
      lrst_r     <= {lrst_r[0], i_reset};
   end

   logic       c_w16;
   logic [3:0] c_slot;
   logic [2:0] c_len;
   logic       c_fall;
   logic       c_style;
   logic       c_lj;
   logic       c_tdm;
   assign {c_w16, c_slot, c_len, c_fall, c_style, c_lj, c_tdm} = cfg_r;

   // Link side: falling-edge capture for the falling-edge mode
   logic fs_neg_r;
   logic sd_neg_r;
   always_ff @(negedge i_bit_clock)
   begin
      fs_neg_r <= i_frame_sync;
      sd_neg_r <= i_serial_audio_in;
   end

   logic                   fs_s;
   logic                   sd_s;
   logic                   fs_prev_r;
   logic                   run_r;
   logic [10:0]            pos_r;
   logic [10:0]            cur;
   logic                   start;
   logic                   active;
   logic [10:0]            base;
   logic [10:0]            last;
   logic [6:0]             slot_len;
   logic [SADC_WORD_W-1:0] shift_r;
   logic [SADC_WORD_W-1:0] word_r;
   logic                   tog_r;

   assign fs_s     = c_fall ? fs_neg_r : i_frame_sync;                        // [R7]
   assign sd_s     = c_fall ? sd_neg_r : i_serial_audio_in;                   // [R7]
   // TDM frames open on the rising sync edge for pulse and 50% styles
   assign start    = (c_tdm || c_style) ? (fs_s && !fs_prev_r)
                                        : (!fs_s && fs_prev_r);               // [R11]
   assign active   = start ? c_lj : run_r;                                    // [R12]
   assign cur      = start ? 11'd0 : pos_r;
   assign slot_len = (c_len <= 3'd4) ? SADC_SLOT_LEN[c_len] : SADC_SLOT_LEN[2]; // [R8]
   assign base     = c_tdm ? 11'(c_slot) * 11'(slot_len) : 11'd0;             // [R8] [R10]
   assign last     = base + (c_w16 ? 11'(SADC_SHORT_W - 1) : 11'(SADC_WORD_W - 1)); // [R14]

   // Positions saturate, so any clock count per frame is accepted
   always_ff @(posedge i_bit_clock)
   begin
      if (lrst_r[1])
      begin
         fs_prev_r <= 1'b0;
         run_r     <= 1'b0;
         pos_r     <= '0;
         shift_r   <= '0;
         word_r    <= '0;
         tog_r     <= 1'b0;
      end
      else
      begin
         fs_prev_r <= fs_s;
         if (start)
         begin
            run_r <= 1'b1;
            pos_r <= c_lj ? 11'd1 : 11'd0;                                    // [R12]
         end
         else if (run_r && pos_r != 11'h7FF)
         begin
            pos_r <= pos_r + 11'd1;                                           // [R9]
         end
         if (active && cur >= base && cur <= last)
         begin
            shift_r <= {shift_r[SADC_WORD_W-2:0], sd_s};                      // [R13]
            if (cur == last)
            begin
               word_r <= c_w16 ? {shift_r[SADC_SHORT_W-2:0], sd_s, 8'h00}
                               : {shift_r[SADC_WORD_W-2:0], sd_s};            // [R14]
               tog_r  <= ~tog_r;
            end
         end
      end
   end

   // Word crossing: toggle event, word stays stable for at least 16 clocks
   logic [2:0]             tog_sync_r;
   logic                   word_evt;
   logic                   fifo_out_valid;
   logic [SADC_WORD_W-1:0] fifo_out_data;
   logic                   fifo_pop;
   logic                   fifo_in_ready;

   assign word_evt = tog_sync_r[2] ^ tog_sync_r[1];

   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         tog_sync_r <= '0;
         o_overrun  <= 1'b0;
         o_in_ready <= 1'b1;
      end
      else if (i_clk_en)
      begin
         tog_sync_r <= {tog_sync_r[1:0], tog_r};
         o_in_ready <= fifo_in_ready;
         if (word_evt && !fifo_in_ready)
         begin
            o_overrun <= 1'b1;
         end
      end
   end

   sadc_fifo #(
      .WIDTH (SADC_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk_sys   (i_clk_sys),
      .i_reset     (i_reset),
      .i_clk_en    (i_clk_en),
      .i_in_valid  (word_evt),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (word_r),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  (fifo_out_data)
   );

   // Output processing, one sample per pop
   logic signed [SADC_WORD_W-1:0] x1_r;
   logic signed [SADC_WORD_W-1:0] y1_r;
   logic [7:0]                    cur_vol_r;
   logic signed [SADC_WORD_W+1:0] hp_wide;
   logic signed [SADC_WORD_W-1:0] hp;
   logic signed [SADC_WORD_W-1:0] x;
   logic signed [SADC_WORD_W-1:0] filt;
   logic signed [40:0]            prod;
   logic signed [40:0]            scaled;
   logic signed [SADC_WORD_W-1:0] gained;
   logic signed [SADC_WORD_W-1:0] outv;
   logic [4:0]                    shamt;

   localparam logic signed [40:0] MAXV = 41'sd8388607;
   localparam logic signed [40:0] MINV = -41'sd8388608;

   assign fifo_pop = fifo_out_valid && (!o_audio_valid || i_audio_ready);
   assign x        = fifo_out_data;
   assign hp_wide  = x - x1_r + y1_r - (y1_r >>> SADC_HPF_SHIFT);
   assign hp       = (hp_wide > 26'sd8388607) ? 24'sh7F_FFFF :
                     (hp_wide < -26'sd8388608) ? 24'sh80_0000 : hp_wide[SADC_WORD_W-1:0];
   assign filt     = conv_r[SADC_BIT_HIGHPASS] ? hp : x;                      // [R2]
   assign shamt    = 5'(SADC_GAIN_BASE_SH) + {1'b0, cur_vol_r[7:4]};          // [R4]
   assign prod     = filt * $signed({1'b0, SADC_GAIN_FRAC[cur_vol_r[3:0]]});  // [R4]
   assign scaled   = prod >>> shamt;
   assign gained   = (scaled > MAXV) ? 24'sh7F_FFFF :
                     (scaled < MINV) ? 24'sh80_0000 : scaled[SADC_WORD_W-1:0];
   // Negating the most negative value would wrap, so clamp it
   assign outv     = !spc1_r[SADC_BIT_INVERT] ? gained :
                     (gained == 24'sh80_0000) ? 24'sh7F_FFFF : -gained;       // [R6]

   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         x1_r <= '0;
         y1_r <= '0;
      end
      else if (i_clk_en && fifo_pop)
      begin
         x1_r <= x;
         y1_r <= conv_r[SADC_BIT_HIGHPASS] ? hp : x;                           // [R2]
      end
   end

   // Soft ramp moves one 0.375 dB step per sample
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         cur_vol_r <= SADC_RST_VOL;
      end
      // Hard mode follows the register at once, so the next sample already uses it
      else if (i_clk_en && conv_r[SADC_BIT_IMMEDIATE])
      begin
         cur_vol_r <= vol_r;                                                   // [R4]
      end
      else if (i_clk_en && fifo_pop && cur_vol_r != vol_r)
      begin
         if (cur_vol_r < vol_r)
         begin
            cur_vol_r <= cur_vol_r + 8'd1;
         end
         else
         begin
            cur_vol_r <= cur_vol_r - 8'd1;
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         o_audio       <= '0;
         o_audio_valid <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (fifo_pop)
         begin
            o_audio_valid <= 1'b1;
            if (cur_vol_r == SADC_VOL_MUTE || conv_r[SADC_BIT_MUTE])     // [R5]
            begin
               o_audio <= '0;
            end
            else
            begin
               o_audio <= outv;                                               // [R5]
            end
         end
         else if (i_audio_ready)
         begin
            o_audio_valid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** core/sadc_pkg.sv ***
/*
 Shared constants of the serial audio input path: register map, reset
 values, field positions, slot lengths and gain table.
 Assumes a host that writes the three registers over the register port and
 an audio source that drives bit clock, frame sync and data.
*/
// Summary of operation
// [R1] Sample-rate field codes 000..101 select six rate bands; 110, 111 reserved.
// [R2] Highpass enable bit 5 inserts the highpass filter; resets to 1.
// [R3] Low-power bit 4 selects converter low-power mode; resets to 1.
// [R4] Volume code steps 0.375 dB; code 0 is +24 dB, 0x40 is 0 dB.
// [R5] Code 0xFE is -71.25 dB, deepest; code 0xFF mutes the output.
// [R6] Output invert bit 7 negates the audio sign; 0 passes it unchanged.
// [R7] Bit 6 low samples data on rising bit clock, high on falling.
// [R8] TDM slot length field [5:3]: 16, 24, 32, 48, 64 clocks; resets 010.
// [R9] Stereo or single-chip TDM accepts any bit clock count per frame.
// [R10] Host programs slot length to match the bus when chips share TDM.
// [R11] Frame sync style bit 2 sets left level and TDM pulse or 50% sync.
// [R12] Alignment bit 1: 0 delays first bit one clock, 1 aligns with edge.
// [R13] Port mode bit 0: 0 stereo formats, 1 TDM; resets to 1.
// [R14] Data width setting 0 means 24-bit words, 1 means 16-bit words.
// [R15] TDM slot from four-bit slot number, or address pin when automatic.
`default_nettype none
package sadc_pkg;
   localparam logic [7:0] SADC_OFS_CONV   = 8'h02;
   localparam logic [7:0] SADC_OFS_VOL    = 8'h03;
   localparam logic [7:0] SADC_OFS_SPC1   = 8'h04;
   localparam logic [7:0] SADC_RST_CONV   = 8'h32;
   localparam logic [7:0] SADC_RST_VOL    = 8'h40;
   localparam logic [7:0] SADC_RST_SPC1   = 8'h11;
   // Converter control fields
   localparam int SADC_BIT_IMMEDIATE = 7;
   localparam int SADC_BIT_MUTE      = 6;
   localparam int SADC_BIT_HIGHPASS  = 5;
   localparam int SADC_BIT_LOWPOWER  = 4;
   localparam int SADC_RATE_LSB      = 0;
   // Serial port control one fields
   localparam int SADC_BIT_INVERT    = 7;
   localparam int SADC_BIT_EDGE      = 6;
   localparam int SADC_SLOTLEN_LSB   = 3;
   localparam int SADC_BIT_STYLE     = 2;
   localparam int SADC_BIT_ALIGN     = 1;
   localparam int SADC_BIT_MODE      = 0;
   localparam logic [7:0] SADC_VOL_MUTE  = 8'hFF;
   localparam int SADC_RATE_BANDS    = 6;
   localparam int SADC_WORD_W        = 24;
   localparam int SADC_SHORT_W       = 16;
   localparam int SADC_FIFO_DEPTH    = 16;
   localparam int SADC_HPF_SHIFT     = 8;
   localparam int SADC_GAIN_BASE_SH  = 11;
   // Bit clocks per slot for codes 000..100
   localparam logic [6:0] SADC_SLOT_LEN [0:4] = '{7'd16, 7'd24, 7'd32, 7'd48, 7'd64};
   // 2^(-k/16) in Q15, one entry per 0.375 dB step inside a 6 dB octave
   localparam logic [15:0] SADC_GAIN_FRAC [0:15] = '{
      16'h8000, 16'h7A93, 16'h7560, 16'h7066, 16'h6BA2, 16'h6712, 16'h62B4, 16'h5E84,
      16'h5A82, 16'h56AC, 16'h52FF, 16'h4F7B, 16'h4C1C, 16'h48E2, 16'h45CB, 16'h42D6};
endpackage
`default_nettype wire

// *** verif/sadc_props.sv ***
/*
 Checker on the ports of sadc_top: register port, rate decode, sample stream.
 Assumes only the i_clk_sys domain is watched.
*/
`default_nettype none
module sadc_props_chk
   import sadc_pkg::*;
(
   // System domain
   input wire logic                       i_clk_sys,
   input wire logic                       i_reset,
   input wire logic                       i_clk_en,
   // Register port
   input wire logic [7:0]                 i_reg_addr,
   input wire logic [7:0]                 i_reg_wdata,
   input wire logic                       i_reg_wr,
   input wire logic                       i_reg_rd,
   input wire logic [7:0]                 o_reg_rdata,
   // Stream and status
   input wire logic [SADC_WORD_W-1:0]     o_audio,
   input wire logic                       o_audio_valid,
   input wire logic                       i_audio_ready,
   input wire logic                       o_overrun,
   input wire logic                       o_converter_low_power,
   input wire logic [SADC_RATE_BANDS-1:0] o_sample_rate_range,
   input wire logic                       o_rate_reserved
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mapped;
   assign mapped = i_reg_addr inside {SADC_OFS_CONV, SADC_OFS_VOL, SADC_OFS_SPC1};
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);
   sequence s_conv_wr;
      i_clk_en && i_reg_wr && i_reg_addr == SADC_OFS_CONV;
   endsequence
   sequence s_wr_rd;
      (i_clk_en && i_reg_wr && mapped) ##2 (i_clk_en && i_reg_rd && i_reg_addr == $past(i_reg_addr, 2));
   endsequence
   a_rate_onehot: assert property (!$past(i_reset) |-> $onehot0(o_sample_rate_range) &&
      o_rate_reserved == (o_sample_rate_range == 6'h00)) else $error("rate outputs disagree");
   a_rate_decode: assert property (s_conv_wr |-> ##2 o_sample_rate_range ==
      (($past(i_reg_wdata[2:0], 2) < 3'h6) ? 6'h01 << $past(i_reg_wdata[2:0], 2) : 6'h00))
      else $error("rate band not decoded");
   a_rate_reserved: assert property (s_conv_wr |-> ##2 o_rate_reserved ==
      ($past(i_reg_wdata[2:0], 2) > 3'h5)) else $error("reserved rate flag wrong");
   a_low_power: assert property (s_conv_wr |-> ##2
      o_converter_low_power == $past(i_reg_wdata[4], 2)) else $error("low power copy wrong");
   a_unmapped_read: assert property (i_clk_en && i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_read_back: assert property (s_wr_rd |=> o_reg_rdata == $past(i_reg_wdata, 3))
      else $error("read back differs");
   a_rdata_hold: assert property (!(i_clk_en && i_reg_rd) |=> $stable(o_reg_rdata))
      else $error("read data moved");
   a_valid_hold: assert property (o_audio_valid && !i_audio_ready |=> o_audio_valid && $stable(o_audio))
      else $error("sample dropped before taken");
   a_overrun_sticky: assert property (o_overrun |=> o_overrun) else $error("overrun flag lost");
endmodule
bind sadc_top sadc_props_chk u_props (.i_clk_sys, .i_reset, .i_clk_en, .i_reg_addr, .i_reg_wdata,
   .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_audio, .o_audio_valid, .i_audio_ready, .o_overrun,
   .o_converter_low_power, .o_sample_rate_range, .o_rate_reserved);
`default_nettype wire

// *** verif/sadc_host_model.sv ***
/*
 Audio source model: free-running bit clock, frame sync and serial data.
 Assumes the bench calls send() with settings matching the port register.
*/
`default_nettype none
module sadc_host_model
(
   // Serial audio link
   output logic o_bit_clock,
   output logic o_frame_sync,
   output logic o_serial_audio_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      o_bit_clock = 1'b0;
      o_frame_sync = 1'b0;
      o_serial_audio_in = 1'b0;
      #3.7;
      forever #7.5 o_bit_clock = ~o_bit_clock;
   end
   // Launch on the edge opposite the sampling one: half a period of hold
   task automatic send(input logic [23:0] w, input int wid, len, chans, slot, tdm, sty, aln, fall);
      int n;
      int k;
      int idx;
      logic [23:0] v;
      n = chans * len;
      for (k = -4; k < n + 2; k++)
      begin
         idx = k - (aln ? 0 : 1);
         v = (idx / len == slot) ? w : ~w;
         if (fall)
            @(posedge o_bit_clock);
         else
            @(negedge o_bit_clock);
         if (k < 0 || k >= n)
            o_frame_sync <= tdm ? 1'b0 : ~sty[0];
         else if (tdm)
            o_frame_sync <= sty ? (k < n / 2) : (k == 0);
         else
            o_frame_sync <= (k < len) ? sty[0] : ~sty[0];
         // Idle data toggles so a stale bit never looks valid
         if (idx >= 0 && idx < n && idx % len < wid)
            o_serial_audio_in <= v[wid - 1 - idx % len];
         else
            o_serial_audio_in <= ~o_serial_audio_in;
      end
   endtask
endmodule
`default_nettype wire

// *** verif/tb_serial_audio_dac_config.sv ***
/*
 Bench for sadc_top: registers, stereo and TDM reception, gain, FIFO fill.
 Assumes sadc_host_model as audio source and the bound checker.
*/
`default_nettype none
`define SADC_CHK(g, e) chk(g, e)
module tb_serial_audio_dac_config;
   import sadc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic        w16 = 1'b0, auto_s = 1'b0, ardy = 1'b0, cen = 1'b1;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
   logic [3:0]  slotn = 4'h0;
   logic [1:0]  aslot = 2'h0;
   logic [23:0] audio;
   logic [5:0]  range;
   logic        bclk, fs, sd, av, in_rdy, ovr, lp, resv;
   int          error_cnt = 0, compares = 0, cyc = 0;
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   sadc_top #(.FIFO_DEPTH(16)) dut (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(cen),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_data_width_16(w16), .i_auto_slot(auto_s), .i_slot_number(slotn), .i_addr_slot(aslot),
      .i_bit_clock(bclk), .i_frame_sync(fs), .i_serial_audio_in(sd), .o_audio(audio),
      .o_audio_valid(av), .i_audio_ready(ardy), .o_in_ready(in_rdy), .o_overrun(ovr),
      .o_converter_low_power(lp), .o_sample_rate_range(range), .o_rate_reserved(resv));
   sadc_host_model host (.o_bit_clock(bclk), .o_frame_sync(fs), .o_serial_audio_in(sd));
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic results();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `SADC_CHK(rdata, e);
   endtask
   task automatic cfg(input logic [7:0] conv, volume_code, spc);
      wreg(SADC_OFS_CONV, conv);
      wreg(SADC_OFS_VOL, volume_code);
      wreg(SADC_OFS_SPC1, spc);
   endtask
   // Waits for a sample, then takes it with a one-cycle ready pulse
   task automatic get(output logic [23:0] v);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (av !== 1'b1 && n < 600);
      `SADC_CHK(av, 1'b1);
      v = audio;
      @(posedge clk);
      ardy <= 1'b1;
      @(posedge clk);
      ardy <= 1'b0;
   endtask
   task automatic t_regs();
      int i;
      logic [7:0] v;
      rchk(SADC_OFS_CONV, 8'h32);
      rchk(SADC_OFS_VOL, 8'h40);
      rchk(SADC_OFS_SPC1, 8'h11);
      `SADC_CHK(lp, 1'b1);
      wreg(8'h05, 8'hFF);
      rchk(8'h05, 8'h00);
      // Write while the clock enable is low must be ignored
      @(posedge clk);
      cen <= 1'b0;
      wreg(SADC_OFS_VOL, 8'h00);
      cen <= 1'b1;
      rchk(SADC_OFS_VOL, 8'h40);
      for (i = 0; i < 8; i++)
      begin
         v = {3'h0, i[0], 1'b0, i[2:0]};
         wreg(SADC_OFS_CONV, v);
         rchk(SADC_OFS_CONV, v);
         `SADC_CHK(range, i < 6 ? 24'h1 << i : 24'h0);
         `SADC_CHK(resv, i > 5);
         `SADC_CHK(lp, i[0]);
      end
   endtask
   task automatic t_stereo();
      int m;
      logic [23:0] w, g, g2;
      cfg(8'h92, 8'h40, 8'h00);
      for (m = 0; m < 8; m++)
      begin
         w = 24'h3A_5C00 + 24'(m);
         wreg(SADC_OFS_SPC1, {1'b0, m[2], 3'h2, m[0], m[1], 1'b0});
         host.send(w, 24, m[0] ? 37 : 24, 2, 0, 0, m[0], m[1], m[2]);
         get(g);
         `SADC_CHK(g, w);
      end
      // Filter on: a repeated level must not pass unchanged
      wreg(SADC_OFS_CONV, 8'hB2);
      host.send(24'h70_0000, 24, 24, 2, 0, 0, 1, 1, 1);
      get(g);
      host.send(24'h70_0000, 24, 24, 2, 0, 0, 1, 1, 1);
      get(g2);
      `SADC_CHK(g2 == g, 1'b0);
   endtask
   task automatic t_gain();
      int i;
      logic [23:0] g;
      logic [7:0] cv [0:5] = '{8'h90, 8'h90, 8'h90, 8'h90, 8'hD0, 8'h90};
      logic [7:0] vl [0:5] = '{8'h30, 8'h00, 8'h50, 8'hFF, 8'h40, 8'h40};
      logic [7:0] sp [0:5] = '{8'h16, 8'h16, 8'h16, 8'h16, 8'h16, 8'h96};
      logic [23:0] ex [0:5] = '{24'h02_468A, 24'h12_3450, 24'h00_91A2, 24'h0, 24'h0, 24'hFE_DCBB};
      for (i = 0; i < 6; i++)
      begin
         cfg(cv[i], vl[i], sp[i]);
         host.send(i == 2 ? 24'h01_2344 : 24'h01_2345, 24, 24, 2, 0, 0, 1, 1, 0);
         get(g);
         `SADC_CHK(g, ex[i]);
      end
   endtask
   task automatic t_tdm();
      int i;
      logic [23:0] w, g;
      int lens [0:4] = '{16, 24, 32, 48, 64};
      int cd [0:4] = '{0, 3, 2, 4, 1};
      int sl [0:4] = '{2, 5, 3, 1, 0};
      int ch [0:4] = '{4, 8, 4, 2, 4};
      int st [0:4] = '{0, 1, 0, 1, 0};
      int al [0:4] = '{0, 1, 1, 0, 0};
      int fa [0:4] = '{0, 0, 1, 1, 0};
      cfg(8'h90, 8'h40, 8'h11);
      for (i = 0; i < 5; i++)
      begin
         w = 24'h5A_3C96 ^ 24'(i);
         @(posedge clk);
         w16 <= (i == 0);
         auto_s <= (i == 2);
         slotn <= (i == 2) ? 4'h0 : 4'(sl[i]);
         aslot <= 2'(sl[i]);
         wreg(SADC_OFS_SPC1, {1'b0, fa[i][0], 3'(cd[i]), st[i][0], al[i][0], 1'b1});
         host.send(w, i ? 24 : 16, lens[cd[i]], ch[i], sl[i], 1, st[i], al[i], fa[i]);
         get(g);
         `SADC_CHK(g, i ? w : {w[15:0], 8'h00});
      end
   endtask
   task automatic t_fifo();
      int i;
      logic [23:0] g;
      cfg(8'h90, 8'h40, 8'h16);
      for (i = 0; i < 20; i++)
         host.send(24'h00_0100 + 24'(i), 24, 24, 2, 0, 0, 1, 1, 0);
      repeat (10) @(posedge clk);
      #1;
      `SADC_CHK(in_rdy, 1'b0);
      `SADC_CHK(ovr, 1'b1);
      for (i = 0; i < 17; i++)
      begin
         get(g);
         `SADC_CHK(g, 24'h00_0100 + 24'(i));
      end
      repeat (20) @(posedge clk);
      #1;
      `SADC_CHK(av, 1'b0);
      `SADC_CHK(in_rdy, 1'b1);
   endtask
   // Ceiling well above the few thousand cycles the run needs
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         results();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_stereo();
      t_gain();
      t_tdm();
      t_fifo();
      results();
   end
endmodule
`default_nettype wire
